/* File: logic/sci_timebase_boot.sv */
// Serial interface time base, register file and serial boot loader.
// Assumes a byte-level transmitter/receiver outside and an external program RAM.
`default_nettype none

module sci_timebase_boot #(
  parameter int PADDR_W = 16
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  // Boot mode pins
  input  wire logic               boot_mode_pin_a_in,
  input  wire logic               boot_mode_pin_b_in,
  input  wire logic               boot_mode_pin_c_in,
  // Peripheral register port
  input  wire logic [15:0]        per_addr_in,
  input  wire logic               per_wr_in,
  input  wire logic               per_rd_in,
  input  wire logic [23:0]        per_wdata_in,
  output logic [23:0]             per_rdata_out,
  // Byte serial engine
  input  wire logic               rx_valid_in,
  input  wire logic [7:0]         rx_byte_in,
  input  wire logic               tx_done_in,
  input  wire logic               ext_clk_in,
  output logic                    tx_load_out,
  output logic [7:0]              tx_byte_out,
  output logic                    tx_is_addr_out,
  output logic                    rx_bit_en_out,
  output logic                    tx_bit_en_out,
  output logic                    rx_sleep_out,
  output logic [8:0]              port_c_control_out,
  // Interrupts
  input  wire logic               timer_ack_in,
  output logic                    timer_irq_out,
  output logic [15:0]             timer_vector_out,
  output logic                    tx_irq_out,
  // Program memory and core
  output logic                    pmem_we_out,
  output logic [PADDR_W-1:0]      pmem_addr_out,
  output logic [23:0]             pmem_wdata_out,
  output logic [2:0]              operating_mode_out,
  output logic                    ccr_clear_out,
  output logic                    exec_start_out,
  output logic [PADDR_W-1:0]      exec_addr_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [23:0]                        serial_control_q;
  logic [23:0]                        serial_clock_control_q;
  logic                               tx_empty_q;
  logic                               rx_full_q;
  logic [7:0]                         rx_data_q;
  logic                               ext_q;
  logic [2:0]                         operating_mode_q;
  sci_timebase_pkg::loader_state_t    ld_q;
  logic [23:0]                        acc_q;
  logic [23:0]                        words_q;
  logic [2:0]                         hdr_q;
  logic [1:0]                         bcnt_q;
  logic                               in_header_q;
  logic [7:0]                         byte_q;
  logic                               tick16;
  logic                               timer_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_ctl   = per_wr_in && per_addr_in == sci_timebase_pkg::SERIAL_CONTROL_OFS;
  wire wr_clk   = per_wr_in && per_addr_in == sci_timebase_pkg::SERIAL_CLOCK_OFS;
  wire wr_pcc   = per_wr_in && per_addr_in == sci_timebase_pkg::PORT_C_CONTROL_OFS;
  wire wr_atx   = per_wr_in && per_addr_in == sci_timebase_pkg::ADDRESS_TX_OFS;
  wire wr_dtx   = per_wr_in && per_addr_in == sci_timebase_pkg::DATA_TXRX_OFS;
  wire rd_rx    = per_rd_in && per_addr_in == sci_timebase_pkg::DATA_TXRX_OFS;
  wire in_boot  = ld_q != sci_timebase_pkg::LD_IDLE;
  wire ind_rst  = port_c_control_out[2:0] == 3'h0;
  wire ld_read  = ld_q == sci_timebase_pkg::LD_WAIT_RX && rx_full_q;
  wire ld_echo  = ld_q == sci_timebase_pkg::LD_WAIT_TX && tx_empty_q;
  wire host_tx  = !in_boot && (wr_atx || wr_dtx) && !ind_rst;
  wire tx_go    = ld_echo || host_tx;
  wire rx_take  = ld_read || (!in_boot && rd_rx);
  wire ext_rise = ext_clk_in && !ext_q;
  wire ext_fall = !ext_clk_in && ext_q;
  wire rx_ext   = serial_clock_control_q[sci_timebase_pkg::RX_EXT_CLK_BIT];
  wire tx_ext   = serial_clock_control_q[sci_timebase_pkg::TX_EXT_CLK_BIT];
  wire [23:0] acc_shift = {byte_q, acc_q[23:8]};
  wire [2:0]  mode_pins = {boot_mode_pin_c_in, boot_mode_pin_b_in, boot_mode_pin_a_in};
  wire [23:0] status_word = {21'h0, rx_full_q, tx_empty_q, 1'b0};
  wire [23:0] rd_word =
      (per_addr_in == sci_timebase_pkg::SERIAL_CONTROL_OFS) ? serial_control_q :
      (per_addr_in == sci_timebase_pkg::SERIAL_STATUS_OFS)  ? status_word :
      (per_addr_in == sci_timebase_pkg::SERIAL_CLOCK_OFS)   ? serial_clock_control_q :
      (per_addr_in == sci_timebase_pkg::DATA_TXRX_OFS)      ? {16'h0, rx_data_q} :
      (per_addr_in == sci_timebase_pkg::PORT_C_CONTROL_OFS) ? {15'h0, port_c_control_out} :
      24'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  sci_divider_chain #(
    .CD_W (sci_timebase_pkg::CD_MSB + 1)
  ) u_chain (
    .clk_in                (clk_in),
    .rst_b_in              (rst_b_in),
    .clock_divide_count_in (serial_clock_control_q[sci_timebase_pkg::CD_MSB:0]),
    .prescale_select_in    (serial_clock_control_q[sci_timebase_pkg::PRESCALE_BIT]),
    .timer_rate_select_in  (serial_control_q[sci_timebase_pkg::TIMER_RATE_BIT]),
    .tick16_out            (tick16),
    .timer_tick_out        (timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, written by software or by the loader
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_control_q       <= sci_timebase_pkg::SERIAL_CONTROL_RST;
      serial_clock_control_q <= sci_timebase_pkg::SERIAL_CLOCK_RST;
      port_c_control_out     <= sci_timebase_pkg::PORT_C_RST;
    end else if (ld_q == sci_timebase_pkg::LD_CONFIG) begin
      serial_control_q       <= sci_timebase_pkg::BOOT_CONTROL_VAL;
      serial_clock_control_q <= sci_timebase_pkg::BOOT_CLOCK_VAL;
      port_c_control_out     <= sci_timebase_pkg::BOOT_PORT_C_VAL;
    end else if (!in_boot) begin
      if (wr_ctl) begin
        serial_control_q <= per_wdata_in;
      end
      if (wr_clk) begin
        serial_clock_control_q <= per_wdata_in;
      end
      if (wr_pcc) begin
        port_c_control_out <= per_wdata_in[sci_timebase_pkg::PORT_C_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_empty_q <= 1'b1;
      rx_full_q  <= 1'b0;
      rx_data_q  <= 8'h00;
    end else begin
      tx_empty_q <= ind_rst || tx_done_in || (tx_empty_q && !tx_go);
      rx_full_q  <= rx_valid_in || (rx_full_q && !rx_take);
      if (rx_valid_in) begin
        rx_data_q <= rx_byte_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit requests and bit clocks
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_load_out    <= 1'b0;
      tx_byte_out    <= 8'h00;
      tx_is_addr_out <= 1'b0;
      ext_q          <= 1'b0;
      rx_bit_en_out  <= 1'b0;
      tx_bit_en_out  <= 1'b0;
    end else begin
      tx_load_out <= tx_go;
      if (ld_echo) begin
        tx_byte_out    <= byte_q;
        tx_is_addr_out <= 1'b0;
      end else if (host_tx) begin
        tx_byte_out    <= per_wdata_in[7:0];
        tx_is_addr_out <= wr_atx;
      end
      ext_q         <= ext_clk_in;
      rx_bit_en_out <= rx_ext ? ext_rise : tick16;
      tx_bit_en_out <= tx_ext ? ext_fall : tick16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and sleep
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_irq_out    <= 1'b0;
      timer_vector_out <= sci_timebase_pkg::TIMER_VECTOR;
      tx_irq_out       <= 1'b0;
      rx_sleep_out     <= 1'b0;
    end else begin
      // Every expiry with the timer interrupt enable bit set re-raises the request, even while it is still pending
      timer_irq_out <= (timer_tick && serial_control_q[sci_timebase_pkg::TIMER_IRQ_EN_BIT])
                    || (timer_irq_out && !timer_ack_in);
      timer_vector_out <= sci_timebase_pkg::TIMER_VECTOR;
      tx_irq_out <= serial_control_q[sci_timebase_pkg::TX_IRQ_EN_BIT] && tx_empty_q;
      if (!in_boot && wr_ctl && per_wdata_in[sci_timebase_pkg::RX_SLEEP_BIT]) begin
        rx_sleep_out <= 1'b1;
      end else if (rx_valid_in) begin
        rx_sleep_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data, one cycle after the read strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      per_rdata_out <= 24'h0;
    end else if (per_rd_in) begin
      per_rdata_out <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot loader sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ld_q             <= sci_timebase_pkg::LD_SAMPLE;
      operating_mode_q <= sci_timebase_pkg::RUN_MODE;
      acc_q            <= 24'h0;
      words_q          <= 24'h0;
      hdr_q            <= 3'h0;
      bcnt_q           <= 2'h0;
      in_header_q      <= 1'b1;
      byte_q           <= 8'h00;
      pmem_addr_out    <= '0;
      exec_addr_out    <= '0;
    end else begin
      case (ld_q)
        sci_timebase_pkg::LD_SAMPLE: begin
          // Pins are caught on the first edge after release, not by the reset
          operating_mode_q <= mode_pins;
          ld_q <= (mode_pins == sci_timebase_pkg::SERIAL_BOOT_MODE)
                ? sci_timebase_pkg::LD_CONFIG : sci_timebase_pkg::LD_IDLE;
        end
        sci_timebase_pkg::LD_CONFIG: begin
          ld_q <= sci_timebase_pkg::LD_WAIT_RX;
        end
        sci_timebase_pkg::LD_WAIT_RX: begin
          if (rx_full_q) begin
            byte_q <= rx_data_q;
            ld_q   <= sci_timebase_pkg::LD_WAIT_TX;
          end
        end
        sci_timebase_pkg::LD_WAIT_TX: begin
          if (tx_empty_q) begin
            acc_q <= acc_shift;
            ld_q  <= sci_timebase_pkg::LD_NEXT;
          end
        end
        sci_timebase_pkg::LD_NEXT: begin
          ld_q <= sci_timebase_pkg::LD_WAIT_RX;
          if (in_header_q) begin
            hdr_q <= hdr_q + 3'h1;
            if (hdr_q == 3'h2) begin
              words_q <= acc_q;
            end
            if (hdr_q == sci_timebase_pkg::HEADER_LAST) begin
              in_header_q   <= 1'b0;
              pmem_addr_out <= acc_q[PADDR_W-1:0];
              exec_addr_out <= acc_q[PADDR_W-1:0];
              if (words_q == 24'h0) begin
                ld_q <= sci_timebase_pkg::LD_FINISH;
              end
            end
          end else begin
            bcnt_q <= (bcnt_q == sci_timebase_pkg::WORD_LAST) ? 2'h0 : bcnt_q + 2'h1;
            if (bcnt_q == sci_timebase_pkg::WORD_LAST) begin
              ld_q <= sci_timebase_pkg::LD_STORE;
            end
          end
        end
        sci_timebase_pkg::LD_STORE: begin
          words_q       <= words_q - 24'h1;
          ld_q <= (words_q == 24'h1) ? sci_timebase_pkg::LD_FINISH : sci_timebase_pkg::LD_WAIT_RX;
        end
        sci_timebase_pkg::LD_FINISH: begin
          operating_mode_q <= sci_timebase_pkg::RUN_MODE;
          ld_q             <= sci_timebase_pkg::LD_IDLE;
        end
        default: begin
          ld_q <= sci_timebase_pkg::LD_IDLE;
        end
      endcase
      // Advance only after the strobe, so each word lands at its own address
      if (pmem_we_out) begin
        pmem_addr_out <= pmem_addr_out + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory writes and hand-off to the core
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pmem_we_out        <= 1'b0;
      pmem_wdata_out     <= 24'h0;
      operating_mode_out <= sci_timebase_pkg::RUN_MODE;
      ccr_clear_out      <= 1'b0;
      exec_start_out     <= 1'b0;
    end else begin
      pmem_we_out        <= ld_q == sci_timebase_pkg::LD_STORE;
      pmem_wdata_out     <= acc_q;
      operating_mode_out <= operating_mode_q;
      ccr_clear_out      <= ld_q == sci_timebase_pkg::LD_FINISH;
      exec_start_out     <= ld_q == sci_timebase_pkg::LD_FINISH;
    end
  end

endmodule : sci_timebase_boot

`default_nettype wire

/* File: shared/sci_timebase_pkg.sv */
// Constants shared by the serial time base and boot loader.
// Assumes a 24-bit peripheral data path and 16-bit peripheral addresses.
`default_nettype none

package sci_timebase_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the peripheral port
  localparam logic [15:0] SERIAL_CONTROL_OFS  = 16'hfff0;
  localparam logic [15:0] SERIAL_STATUS_OFS   = 16'hfff1;
  localparam logic [15:0] SERIAL_CLOCK_OFS    = 16'hfff2;
  localparam logic [15:0] ADDRESS_TX_OFS      = 16'hfff3;
  localparam logic [15:0] DATA_TXRX_OFS       = 16'hfff4;
  localparam logic [15:0] PORT_C_CONTROL_OFS  = 16'hffe1;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CD_MSB          = 11;
  localparam int PRESCALE_BIT    = 13;
  localparam int RX_EXT_CLK_BIT  = 14;
  localparam int TX_EXT_CLK_BIT  = 15;
  localparam int RX_SLEEP_BIT    = 6;
  localparam int TX_IRQ_EN_BIT   = 12;
  localparam int TIMER_IRQ_EN_BIT = 13;
  localparam int TIMER_RATE_BIT  = 14;
  localparam int TX_EMPTY_BIT    = 1;
  localparam int RX_FULL_BIT     = 2;
  localparam int PORT_C_MSB      = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and boot values
  localparam logic [23:0] SERIAL_CONTROL_RST = 24'h000000;
  localparam logic [23:0] SERIAL_CLOCK_RST   = 24'h000000;
  localparam logic [8:0]  PORT_C_RST         = 9'h000;
  localparam logic [23:0] BOOT_CONTROL_VAL   = 24'h000302;
  localparam logic [23:0] BOOT_CLOCK_VAL     = 24'h00c000;
  localparam logic [8:0]  BOOT_PORT_C_VAL    = 9'h007;
  localparam logic [2:0]  SERIAL_BOOT_MODE   = 3'h6;
  localparam logic [2:0]  RUN_MODE           = 3'h0;
  localparam logic [15:0] TIMER_VECTOR       = 16'h001c;

  ////////////////////////////////////////////////////////////////////////////
  // Time base division figures and loader header/word byte counts
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [3:0] SIXTEEN_LAST  = 4'hf;
  localparam logic [2:0] HEADER_LAST   = 3'h5;
  localparam logic [1:0] WORD_LAST     = 2'h2;

  typedef enum logic [3:0] {
    LD_SAMPLE  = 4'b0000,
    LD_IDLE    = 4'b0001,
    LD_CONFIG  = 4'b0010,
    LD_WAIT_RX = 4'b0011,
    LD_WAIT_TX = 4'b0100,
    LD_NEXT    = 4'b0101,
    LD_STORE   = 4'b0110,
    LD_FINISH  = 4'b0111
  } loader_state_t;

endpackage : sci_timebase_pkg

`default_nettype wire

/* File: logic/sci_divider_chain.sv */
// Divider chain producing the 16x bit-rate tick and the periodic timer tick.
// Assumes divide count and selects are stable register outputs.
`default_nettype none

module sci_divider_chain #(
  parameter int CD_W = 12
) (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  // Controls
  input  wire logic [CD_W-1:0] clock_divide_count_in,
  input  wire logic            prescale_select_in,
  input  wire logic            timer_rate_select_in,
  // Ticks
  output logic                 tick16_out,
  output logic                 timer_tick_out
);

  logic            phase_q;
  logic [CD_W-1:0] cnt_q;
  logic [2:0]      pre_q;
  logic            half_q;
  logic [3:0]      six_q;

  wire div_tick = phase_q && (cnt_q == '0);
  wire pre_tick = div_tick && (!prescale_select_in || pre_q == sci_timebase_pkg::PRESCALE_LAST);
  wire half_tick = pre_tick && half_q;
  wire timer_tick = timer_rate_select_in ? pre_tick
                  : (half_tick && six_q == sci_timebase_pkg::SIXTEEN_LAST);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      phase_q <= !phase_q;
      if (phase_q) begin
        cnt_q <= (cnt_q == '0) ? clock_divide_count_in
                               : cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_q  <= 3'h0;
      half_q <= 1'b0;
      six_q  <= 4'h0;
    end else begin
      if (div_tick) begin
        pre_q <= pre_tick ? 3'h0 : pre_q + 3'h1;
      end
      if (pre_tick) begin
        half_q <= !half_q;
      end
      if (half_tick) begin
        six_q <= six_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick16_out     <= 1'b0;
      timer_tick_out <= 1'b0;
    end else begin
      tick16_out     <= half_tick;
      timer_tick_out <= timer_tick;
    end
  end

endmodule : sci_divider_chain

`default_nettype wire

/* File: test/sci_timebase_checker.sv */
// Port assertions for the serial time base and boot loader.
// Assumes one clock domain with async active-low reset.
`default_nettype none

module sci_timebase_checker (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // Watched ports
  input wire logic        boot_mode_pin_a_in,
  input wire logic        boot_mode_pin_b_in,
  input wire logic        boot_mode_pin_c_in,
  input wire logic        timer_ack_in,
  input wire logic        timer_irq_out,
  input wire logic [15:0] timer_vector_out,
  input wire logic        tx_load_out,
  input wire logic        tx_is_addr_out,
  input wire logic        pmem_we_out,
  input wire logic [2:0]  operating_mode_out,
  input wire logic        ccr_clear_out,
  input wire logic        exec_start_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  ////////////////////////////////////////////////////////////////////////////
  sequence finish_s;
    ccr_clear_out ##1 (!exec_start_out && operating_mode_out == 3'h0);
  endsequence

  chk_vector_fixed: assert property (timer_vector_out == 16'h001c)
    else $error("timer vector wrong");
  chk_irq_holds: assert property (timer_irq_out && !timer_ack_in |=> timer_irq_out)
    else $error("timer pending dropped without service");
  chk_echo_data: assert property (tx_load_out && operating_mode_out == 3'h6 |-> !tx_is_addr_out)
    else $error("echo sent as address character");
  chk_load_spaced: assert property (tx_load_out |=> !tx_load_out)
    else $error("echo reloaded before transmitter free");
  chk_we_single: assert property (pmem_we_out |=> !pmem_we_out [*2])
    else $error("word stored without three bytes");
  chk_we_boot: assert property (pmem_we_out |-> operating_mode_out == 3'h6)
    else $error("program store outside serial boot");
  chk_finish_pair: assert property (exec_start_out |-> finish_s)
    else $error("finish without flag clear or mode zero");
  chk_mode_sample: assert property (!$past(rst_b_in) |=> ##1
    operating_mode_out == $past({boot_mode_pin_c_in, boot_mode_pin_b_in, boot_mode_pin_a_in}, 2))
    else $error("mode pins not copied");
endmodule : sci_timebase_checker

bind sci_timebase_boot sci_timebase_checker sci_timebase_checker_i (.clk_in, .rst_b_in,
  .boot_mode_pin_a_in, .boot_mode_pin_b_in, .boot_mode_pin_c_in, .timer_ack_in, .timer_irq_out,
  .timer_vector_out, .tx_load_out, .tx_is_addr_out, .pmem_we_out, .operating_mode_out,
  .ccr_clear_out, .exec_start_out);

`default_nettype wire

/* File: test/sci_host_model.sv */
// Host on the serial side: feeds bytes, frees the transmitter, makes the 16x clock.
// Assumes the bench calls send_byte and waits for each echo.
`default_nettype none

module sci_host_model (
  // Clock
  input  wire logic       clk_in,
  // From the loader
  input  wire logic       tx_load_in,
  input  wire logic [7:0] tx_byte_in,
  // To the loader
  output logic            rx_valid_out,
  output logic [7:0]      rx_byte_out,
  output logic            tx_done_out,
  output logic            ext_clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] echo_q[$];
  int         busy_q = 0;
  int         div_q  = 0;

  initial begin
    rx_valid_out = 1'b0;
    rx_byte_out  = 8'h00;
    tx_done_out  = 1'b0;
    ext_clk_out  = 1'b0;
  end

  // External 16x clock, eight system cycles a period
  always @(posedge clk_in) begin
    div_q <= (div_q + 1) % 4;
    if (div_q == 3) begin
      ext_clk_out <= ~ext_clk_out;
    end
  end

  // Transmitter busy for a random few cycles per echo
  always @(posedge clk_in) begin
    tx_done_out <= (busy_q == 1);
    if (tx_load_in) begin
      echo_q.push_back(tx_byte_in);
      busy_q <= 2 + $urandom_range(3);
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 1;
    end
  end

  // Released data shows the inverse, never a stale value
  task automatic send_byte(input logic [7:0] b);
    int n;
    n = echo_q.size();
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_byte_out  <= b;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out  <= ~b;
    for (int i = 0; i < 100 && echo_q.size() == n; i++) @(posedge clk_in);
    repeat (6) @(posedge clk_in);
  endtask : send_byte
endmodule : sci_host_model

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench: serial boot load, then timer periods after a second reset.
// Assumes the host model on the serial side and the bound checker.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'b0, rst_b_in = 1'b0, per_wr_in = 1'b0, per_rd_in = 1'b0, timer_ack_in = 1'b0;
  logic [2:0]  mode_q = 3'h6, operating_mode_out;
  logic [15:0] per_addr_in = 16'h0000, timer_vector_out, pmem_addr_out, exec_addr_out;
  logic [23:0] per_wdata_in = 24'h000000, per_rdata_out, pmem_wdata_out;
  logic [8:0]  port_c_control_out;
  logic [7:0]  rx_byte_in, tx_byte_out, sent_q[$];
  logic        rx_valid_in, tx_done_in, ext_clk_in, tx_load_out, tx_is_addr_out, rx_bit_en_out;
  logic        tx_bit_en_out, rx_sleep_out, timer_irq_out, tx_irq_out, pmem_we_out, ccr_clear_out, exec_start_out;
  logic [39:0] mem_q[$];
  int          bad_count = 0, total_checks = 0, cyc = 0, start_count = 0;

  initial forever #2.5 clk_in = ~clk_in;

  sci_timebase_boot sci_timebase_boot_i (.clk_in, .rst_b_in, .boot_mode_pin_a_in(mode_q[0]),
    .boot_mode_pin_b_in(mode_q[1]), .boot_mode_pin_c_in(mode_q[2]), .per_addr_in, .per_wr_in, .per_rd_in,
    .per_wdata_in, .per_rdata_out, .rx_valid_in, .rx_byte_in, .tx_done_in, .ext_clk_in, .tx_load_out,
    .tx_byte_out, .tx_is_addr_out, .rx_bit_en_out, .tx_bit_en_out, .rx_sleep_out, .port_c_control_out,
    .timer_ack_in, .timer_irq_out, .timer_vector_out, .tx_irq_out, .pmem_we_out, .pmem_addr_out,
    .pmem_wdata_out, .operating_mode_out, .ccr_clear_out, .exec_start_out, .exec_addr_out);
  sci_host_model host_i (.clk_in, .tx_load_in(tx_load_out), .tx_byte_in(tx_byte_out),
    .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in), .tx_done_out(tx_done_in), .ext_clk_out(ext_clk_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (pmem_we_out) begin
      mem_q.push_back({pmem_addr_out, pmem_wdata_out});
    end
    if (exec_start_out === 1'b1) begin
      start_count <= start_count + 1;
    end
    if (cyc == 60000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [15:0] a, input logic [23:0] d);
    @(posedge clk_in);
    per_addr_in  <= a;
    per_wdata_in <= d;
    per_wr_in    <= 1'b1;
    @(posedge clk_in);
    per_wr_in    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [23:0] exp);
    @(posedge clk_in);
    per_addr_in <= a;
    per_rd_in   <= 1'b1;
    @(posedge clk_in);
    per_rd_in   <= 1'b0;
    @(negedge clk_in);
    chk(40'(per_rdata_out), 40'(exp));
  endtask : reg_rd

  task automatic wait_irq;
    for (int n = 0; n < 3000 && timer_irq_out !== 1'b1; n++) @(negedge clk_in);
  endtask : wait_irq

  // Service one pending timer interrupt, then expect it gone
  task automatic ack;
    @(posedge clk_in);
    timer_ack_in <= 1'b1;
    @(posedge clk_in);
    timer_ack_in <= 1'b0;
    @(negedge clk_in);
    chk(40'(timer_irq_out), 40'h0);
  endtask : ack

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [47:0] hdr;
    logic [23:0] w[2];
    logic [11:0] cd;
    int          t0;
    int          ne[2];
    void'($urandom(32725));
    w[0] = 24'($urandom);
    w[1] = 24'hffffff;
    hdr  = {8'h00, 16'($urandom), 24'h000002};
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 12; i++) begin
      sent_q.push_back(i < 6 ? hdr[8*i+:8] : w[(i-6)/3][8*((i-6)%3)+:8]);
      host_i.send_byte(sent_q[i]);
    end
    for (int n = 0; n < 50 && exec_start_out !== 1'b1; n++) @(negedge clk_in);
    chk(40'(exec_addr_out), 40'(hdr[39:24]));
    chk(40'(start_count), 40'h1);
    chk(40'(port_c_control_out), 40'h007);
    chk(40'(mem_q.size()), 40'h2);
    for (int k = 0; k < 2; k++) chk(mem_q[k], {hdr[39:24] + 16'(k), w[k]});
    for (int i = 0; i < 12; i++) chk(40'(host_i.echo_q[i]), 40'(sent_q[i]));
    repeat (4) @(posedge clk_in);
    reg_rd(16'hfff0, 24'h000302);
    reg_rd(16'hfff2, 24'h00c000);
    // Host clock period is eight cycles, so 64 cycles hold eight of each edge
    for (int n = 0; n < 64; n++) begin
      @(negedge clk_in);
      ne[0] += int'(rx_bit_en_out === 1'b1 && ext_clk_in === 1'b1);
      ne[1] += int'(tx_bit_en_out === 1'b1 && ext_clk_in === 1'b0);
    end
    chk(40'(ne[0]), 40'h8);
    chk(40'(ne[1]), 40'h8);
    rst_b_in <= 1'b0;
    mode_q   <= 3'($urandom_range(5));
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(40'(operating_mode_out), 40'(mode_q));
    reg_rd(16'hfff1, 24'h000002);
    reg_rd(16'hffe0, 24'h000000);
    for (int k = 0; k < 4; k++) begin
      cd = 12'($urandom_range(3) + 1);
      reg_wr(16'hfff2, {10'h000, k[0], 1'b0, cd});
      reg_wr(16'hfff0, {9'h000, k[1], 1'b1, 1'b0, 12'h000});
      wait_irq();
      ack();
      wait_irq();
      ack();
      wait_irq();
      t0 = cyc;
      ack();
      wait_irq();
      chk(40'(cyc - t0), 40'((k[1] ? 2 : 64) * (k[0] ? 8 : 1) * (cd + 1)));
      chk(40'(tx_irq_out), 40'h0);
      ack();
    end
    reg_wr(16'hfff0, 24'h001040);
    repeat (2) @(negedge clk_in);
    chk(40'(rx_sleep_out), 40'h1);
    chk(40'(tx_irq_out), 40'h1);
    test_done();
  end
endmodule : testbench

`default_nettype wire
